// ---- core/tcc_defs.vh ----
// register map, field positions and reset values of the capture timer
// assumes 32-bit apb data with one aligned word per register
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

`define TCC_OFF_CTRL_A 8'h00
`define TCC_OFF_CTRL_B 8'h04
`define TCC_OFF_CTRL_C 8'h08
`define TCC_OFF_CNT_LO 8'h0c
`define TCC_OFF_CNT_HI 8'h10
`define TCC_OFF_CAP_LO 8'h14
`define TCC_OFF_CAP_HI 8'h18
`define TCC_OFF_CMPA_LO 8'h1c
`define TCC_OFF_CMPA_HI 8'h20
`define TCC_OFF_FLAGS 8'h24
`define TCC_OFF_IRQ_EN 8'h28

// control_reg_a: waveform mode low bits
`define TCC_A_WGM_LO 1:0
// control_reg_b: clock source, waveform mode high bits, edge, filter
`define TCC_B_CS 2:0
`define TCC_B_WGM_HI 4:3
`define TCC_B_EDGE 6
`define TCC_B_FILT 7
// control_c: trigger source and retrigger enable
`define TCC_C_SRC 1:0
`define TCC_C_RTG 2
// flags and interrupt enables share bit positions
`define TCC_F_OVF 0
`define TCC_F_CAP 5

`define TCC_RST_CTRL 8'h00
`define TCC_RST_CNT 16'h0000
`define TCC_RST_CMPA 16'hffff

`define TCC_TOP_8 16'h00ff
`define TCC_TOP_9 16'h01ff
`define TCC_TOP_10 16'h03ff
`define TCC_TOP_MAX 16'hffff

// trigger sources
`define TCC_SRC_PIN_A 2'h0
`define TCC_SRC_PIN_B 2'h1
`define TCC_SRC_CMP 2'h2

// agreeing samples needed by the noise filter
`define TCC_FILT_LEN 4
`endif

// ---- core/tcc_timer.v ----
// 16-bit up/down timer with input capture, apb register slave
// assumes pins and prescaler taps synchronous to pclk, prescaler outside
//
// Notes on behaviour
// - upper-byte writes and count/capture upper reads go to shared holding byte
// - lower count read copies upper into holding
// - lower count write loads holding plus lower
// - clock select picks tick; zero stops
// - cpu count write beats counting
// - each tick clears, increments or decrements
// - four-bit mode split across control a/b
// - overflow flag per mode, can interrupt
// - top, bottom and retrigger request generated
// - matching edge copies count into capture
// - capture flag same cycle; irq when enabled
// - flag clears on service or write-one
// - lower capture read copies upper into holding
// - capture writable only in capture-top modes
// - capture flag can retrigger like top
// - changing trigger source may capture
// - filter adds four clocks of delay
// - capture input off in capture-top modes
// - filter output needs four agreeing samples
// - filter enabled by control b, pclk
// - software may drive capture pin itself
// - top is fixed, compare a or capture
// - retrigger ored into top when enabled
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "tcc_defs.vh"

module tcc_timer (
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata_q,
   output reg pready_q,
   output reg pslverr_q,
   // timer tick sources
   input wire [3:0] presc_tick,
   input wire ext_clk_pin,
   // capture sources
   input wire capture_pin_a,
   input wire capture_pin_b,
   input wire comparator_output,
   // interrupt requests and service acknowledges
   input wire ovf_irq_ack,
   input wire cap_irq_ack,
   output reg ovf_irq_q,
   output reg cap_irq_q
);

   reg [7:0] control_reg_a_q;
   reg [7:0] control_reg_b_q;
   reg [7:0] control_c_q;
   reg [7:0] holding_q;
   reg [15:0] timer_count_q;
   reg [15:0] timer_count_d;
   reg count_down_q;
   reg count_down_d;
   reg [15:0] capture_value_q;
   reg [15:0] compare_a_value_q;
   reg overflow_flag_q;
   reg capture_flag_q;
   reg ovf_ie_q;
   reg capture_irq_enable_q;
   reg ext_prev_q;
   reg src_q;
   reg [`TCC_FILT_LEN-1:0] filt_sh_q;
   reg filt_q;
   reg edge_prev_q;
   reg retrig_pend_q;
   reg [31:0] rdata_d;
   reg map_ok;
   reg timer_tick;
   reg [15:0] top_val;
   reg dual_slope;
   reg ovf_event;

   wire [3:0] waveform_mode_select;
   wire [2:0] clock_source_select;
   wire access;
   wire xfer;
   wire wr;
   wire rd;
   wire cap_top_mode;
   wire cap_input;
   wire cap_level;
   wire cap_event;
   wire top_hit;
   wire bottom_hit;
   wire retrigger_request;
   wire wr_cnt_lo;
   wire wr_flags;

   assign waveform_mode_select = {control_reg_b_q[`TCC_B_WGM_HI], control_reg_a_q[`TCC_A_WGM_LO]};
   assign clock_source_select = control_reg_b_q[`TCC_B_CS];

   // one wait state so prdata can come from a flop
   assign access = psel & penable;
   assign xfer = access & pready_q;
   assign wr = xfer & pwrite;
   // read side effects ride the edge that loads prdata, so both bytes match
   assign rd = access & ~pready_q & ~pwrite;
   assign wr_cnt_lo = wr & (paddr == `TCC_OFF_CNT_LO);
   assign wr_flags = wr & (paddr == `TCC_OFF_FLAGS);

   assign cap_top_mode = (waveform_mode_select == 4'h8) | (waveform_mode_select == 4'ha) |
                         (waveform_mode_select == 4'hc) | (waveform_mode_select == 4'he);

   // pin read back as-is, so port driving works
   assign cap_input = (control_c_q[`TCC_C_SRC] == `TCC_SRC_PIN_B) ? capture_pin_b :
                      (control_c_q[`TCC_C_SRC] == `TCC_SRC_CMP) ? comparator_output : capture_pin_a;

   // filtered path is four clocks longer
   assign cap_level = control_reg_b_q[`TCC_B_FILT] ? filt_q : src_q;

   // a source change with a level step captures too
   assign cap_event = ~cap_top_mode & (cap_level != edge_prev_q) &
                      (cap_level == control_reg_b_q[`TCC_B_EDGE]);

   assign retrigger_request = control_c_q[`TCC_C_RTG] & retrig_pend_q;
   assign bottom_hit = (timer_count_q == 16'h0000);
   assign top_hit = (timer_count_q == top_val) | retrigger_request;

   always @* begin
      case (clock_source_select)
         3'h0: timer_tick = 1'b0;
         3'h1: timer_tick = 1'b1;
         3'h2: timer_tick = presc_tick[0];
         3'h3: timer_tick = presc_tick[1];
         3'h4: timer_tick = presc_tick[2];
         3'h5: timer_tick = presc_tick[3];
         3'h6: timer_tick = ext_prev_q & ~ext_clk_pin;
         3'h7: timer_tick = ~ext_prev_q & ext_clk_pin;
         default: timer_tick = 1'b0;
      endcase
   end

   always @* begin
      dual_slope = 1'b0;
      case (waveform_mode_select)
         4'h1: begin
            top_val = `TCC_TOP_8;
            dual_slope = 1'b1;
         end
         4'h2: begin
            top_val = `TCC_TOP_9;
            dual_slope = 1'b1;
         end
         4'h3: begin
            top_val = `TCC_TOP_10;
            dual_slope = 1'b1;
         end
         4'h4: top_val = compare_a_value_q;
         4'h5: top_val = `TCC_TOP_8;
         4'h6: top_val = `TCC_TOP_9;
         4'h7: top_val = `TCC_TOP_10;
         4'h8: begin
            top_val = capture_value_q;
            dual_slope = 1'b1;
         end
         4'h9: begin
            top_val = compare_a_value_q;
            dual_slope = 1'b1;
         end
         4'ha: begin
            top_val = capture_value_q;
            dual_slope = 1'b1;
         end
         4'hb: begin
            top_val = compare_a_value_q;
            dual_slope = 1'b1;
         end
         4'hc: top_val = capture_value_q;
         4'he: top_val = capture_value_q;
         4'hf: top_val = compare_a_value_q;
         default: top_val = `TCC_TOP_MAX;
      endcase
   end

   always @* begin
      timer_count_d = timer_count_q;
      count_down_d = count_down_q;
      ovf_event = 1'b0;
      if (timer_tick) begin
         if (dual_slope) begin
            if (!count_down_q && top_hit) begin
               count_down_d = 1'b1;
               timer_count_d = timer_count_q - 16'h0001;
            end else if (count_down_q && bottom_hit) begin
               count_down_d = 1'b0;
               timer_count_d = timer_count_q + 16'h0001;
               ovf_event = 1'b1;
            end else if (count_down_q) begin
               timer_count_d = timer_count_q - 16'h0001;
            end else begin
               timer_count_d = timer_count_q + 16'h0001;
            end
         end else begin
            count_down_d = 1'b0;
            if (top_hit) begin
               timer_count_d = 16'h0000;
               ovf_event = 1'b1;
            end else begin
               timer_count_d = timer_count_q + 16'h0001;
            end
         end
      end
      // holding byte and low byte land together
      if (wr_cnt_lo) begin
         timer_count_d = {holding_q, pwdata[7:0]};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_count_q <= `TCC_RST_CNT;
         count_down_q <= 1'b0;
         ext_prev_q <= 1'b0;
         retrig_pend_q <= 1'b0;
      end else begin
         timer_count_q <= timer_count_d;
         count_down_q <= count_down_d;
         ext_prev_q <= ext_clk_pin;
         // retrigger waits for the next tick, then is consumed
         if (cap_event) begin
            retrig_pend_q <= 1'b1;
         end else if (timer_tick) begin
            retrig_pend_q <= 1'b0;
         end
      end
   end

   // capture input sampling and noise filter
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q <= 1'b0;
         filt_sh_q <= {`TCC_FILT_LEN{1'b0}};
         filt_q <= 1'b0;
         edge_prev_q <= 1'b0;
      end else begin
         src_q <= cap_input;
         // filter runs on pclk, not the prescaler
         // taps the pin beside src_q so the filtered path is exactly four clocks longer
         filt_sh_q <= {filt_sh_q[`TCC_FILT_LEN-2:0], cap_input};
         if (&filt_sh_q) begin
            filt_q <= 1'b1;
         end else if (~|filt_sh_q) begin
            filt_q <= 1'b0;
         end
         edge_prev_q <= cap_level;
      end
   end

   // registers, holding byte, capture and flags
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_reg_a_q <= `TCC_RST_CTRL;
         control_reg_b_q <= `TCC_RST_CTRL;
         control_c_q <= `TCC_RST_CTRL;
         holding_q <= 8'h00;
         capture_value_q <= `TCC_RST_CNT;
         compare_a_value_q <= `TCC_RST_CMPA;
         overflow_flag_q <= 1'b0;
         capture_flag_q <= 1'b0;
         ovf_ie_q <= 1'b0;
         capture_irq_enable_q <= 1'b0;
      end else begin
         if (wr) begin
            case (paddr)
               `TCC_OFF_CTRL_A: control_reg_a_q <= pwdata[7:0];
               `TCC_OFF_CTRL_B: control_reg_b_q <= pwdata[7:0];
               `TCC_OFF_CTRL_C: control_c_q <= pwdata[7:0];
               // every upper byte write hits the holding byte
               `TCC_OFF_CNT_HI: holding_q <= pwdata[7:0];
               `TCC_OFF_CAP_HI: holding_q <= pwdata[7:0];
               `TCC_OFF_CMPA_HI: holding_q <= pwdata[7:0];
               `TCC_OFF_CMPA_LO: compare_a_value_q <= {holding_q, pwdata[7:0]};
               `TCC_OFF_CAP_LO: begin
                  if (cap_top_mode) begin
                     capture_value_q <= {holding_q, pwdata[7:0]};
                  end
               end
               `TCC_OFF_IRQ_EN: begin
                  ovf_ie_q <= pwdata[`TCC_F_OVF];
                  capture_irq_enable_q <= pwdata[`TCC_F_CAP];
               end
               default: ;
            endcase
         end
         // low count read latches high byte
         if (rd && paddr == `TCC_OFF_CNT_LO) begin
            holding_q <= timer_count_q[15:8];
         end
         // low capture read latches high byte
         if (rd && paddr == `TCC_OFF_CAP_LO) begin
            holding_q <= capture_value_q[15:8];
         end
         if (cap_event) begin
            capture_value_q <= timer_count_q;
         end
         // set beats any clear in the same cycle
         if (cap_event) begin
            capture_flag_q <= 1'b1;
         end else if (cap_irq_ack || (wr_flags && pwdata[`TCC_F_CAP])) begin
            capture_flag_q <= 1'b0;
         end
         if (ovf_event) begin
            overflow_flag_q <= 1'b1;
         end else if (ovf_irq_ack || (wr_flags && pwdata[`TCC_F_OVF])) begin
            overflow_flag_q <= 1'b0;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_irq_q <= 1'b0;
         cap_irq_q <= 1'b0;
      end else begin
         ovf_irq_q <= overflow_flag_q & ovf_ie_q;
         cap_irq_q <= capture_flag_q & capture_irq_enable_q;
      end
   end

   // read mux; compare a upper is read directly, no holding byte
   always @* begin
      rdata_d = 32'h0000_0000;
      map_ok = 1'b1;
      case (paddr)
         `TCC_OFF_CTRL_A: rdata_d[7:0] = control_reg_a_q;
         `TCC_OFF_CTRL_B: rdata_d[7:0] = control_reg_b_q;
         `TCC_OFF_CTRL_C: rdata_d[7:0] = control_c_q;
         `TCC_OFF_CNT_LO: rdata_d[7:0] = timer_count_q[7:0];
         // count and capture upper reads return the holding byte
         `TCC_OFF_CNT_HI: rdata_d[7:0] = holding_q;
         `TCC_OFF_CAP_LO: rdata_d[7:0] = capture_value_q[7:0];
         `TCC_OFF_CAP_HI: rdata_d[7:0] = holding_q;
         `TCC_OFF_CMPA_LO: rdata_d[7:0] = compare_a_value_q[7:0];
         `TCC_OFF_CMPA_HI: rdata_d[7:0] = compare_a_value_q[15:8];
         `TCC_OFF_FLAGS: begin
            rdata_d[`TCC_F_OVF] = overflow_flag_q;
            rdata_d[`TCC_F_CAP] = capture_flag_q;
         end
         `TCC_OFF_IRQ_EN: begin
            rdata_d[`TCC_F_OVF] = ovf_ie_q;
            rdata_d[`TCC_F_CAP] = capture_irq_enable_q;
         end
         default: map_ok = 1'b0;
      endcase
   end

   // apb answer: data sampled on first access cycle, ready next
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         if (access && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= ~map_ok;
            prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
         end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
         end
      end
   end

endmodule

// ---- verif/tcc_tick_model.sv ----
// prescaler and external count pin model feeding the timer tick inputs
// assumes one pclk domain; taps pulse for one cycle every 2, 4, 8, 16 clocks
`timescale 1ns/1ps

module tcc_tick_model (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // tick sources
   output logic [3:0] presc_tick,
   output logic ext_clk_pin
);
   logic [7:0] div_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end
   // taps are free running so the timer sees pulses even while stopped
   assign presc_tick = {&div_q[3:0], &div_q[2:0], &div_q[1:0], div_q[0]};
   assign ext_clk_pin = div_q[3];
endmodule

// ---- verif/tcc_timer_monitor.sv ----
// bus handshake and interrupt checks of the capture timer
// assumes bind onto the timer top, single pclk domain
`timescale 1ns/1ps

module tcc_timer_monitor (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pready_q,
   input wire pslverr_q,
   // interrupts
   input wire ovf_irq_ack,
   input wire cap_irq_ack,
   input wire ovf_irq_q,
   input wire cap_irq_q,
   // capture sources
   input wire capture_pin_a,
   input wire capture_pin_b,
   input wire comparator_output
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wait;
      psel && penable && !pready_q;
   endsequence
   sequence s_done;
      psel && penable && pready_q;
   endsequence
   a_ready_one_wait: assert property ($rose(penable) && psel |=> pready_q) else $error("no one-wait answer");
   a_ready_pulse_once: assert property (s_wait ##1 s_done |=> !pready_q) else $error("ready held too long");
   a_ready_needs_req: assert property (pready_q |-> psel && penable) else $error("ready without request");
   a_ready_idle_bus: assert property (!psel |=> !pready_q) else $error("ready after idle bus");
   a_err_with_ready: assert property (pslverr_q |-> pready_q) else $error("error without ready");
   a_reset_quiet_out: assert property ($past(!presetn) |-> !pready_q && !ovf_irq_q && !cap_irq_q)
      else $error("outputs not quiet after reset");
   a_cap_ack_clears: assert property (cap_irq_ack && $stable(capture_pin_a) && $stable(capture_pin_b)
      && $stable(comparator_output) |=> ##1 !cap_irq_q) else $error("capture irq not cleared");
   a_ovf_ack_clears: assert property (ovf_irq_ack |=> ##1 !ovf_irq_q) else $error("overflow irq not cleared");
   c_capture_seen: cover property (cap_irq_q);
endmodule

bind tcc_timer tcc_timer_monitor u_tcc_timer_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready_q(pready_q), .pslverr_q(pslverr_q), .ovf_irq_ack(ovf_irq_ack),
   .cap_irq_ack(cap_irq_ack), .ovf_irq_q(ovf_irq_q), .cap_irq_q(cap_irq_q), .capture_pin_a(capture_pin_a),
   .capture_pin_b(capture_pin_b), .comparator_output(comparator_output));

// ---- verif/tcc_timer_tb.sv ----
// self-checking bench of the capture timer over apb
// assumes the tick model drives the prescaler taps and the count pin
`timescale 1ns/1ps
`include "tcc_defs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end

module tcc_timer_tb;
   logic pclk, presetn, psel, penable, pwrite, ovf_irq_ack, cap_irq_ack, serr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata_q, rd;
   logic pready_q, pslverr_q, ovf_irq_q, cap_irq_q, ext_clk_pin;
   logic [3:0] presc_tick;
   logic [2:0] pins;
   logic [15:0] v;
   int err_total, checks;
   tcc_tick_model u_tcc_tick_model (.pclk(pclk), .presetn(presetn), .presc_tick(presc_tick),
      .ext_clk_pin(ext_clk_pin));
   tcc_timer u_tcc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
      .presc_tick(presc_tick), .ext_clk_pin(ext_clk_pin), .capture_pin_a(pins[0]), .capture_pin_b(pins[1]),
      .comparator_output(pins[2]), .ovf_irq_ack(ovf_irq_ack), .cap_irq_ack(cap_irq_ack),
      .ovf_irq_q(ovf_irq_q), .cap_irq_q(cap_irq_q));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task wrap_up;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // idle edge first so a release is never overwritten in the same step
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready_q !== 1'b1 && n < 20);
      rd = prdata_q;
      serr = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready_q !== 1'b1) begin
         err_total++;
         wrap_up();
      end
   endtask
   task w16(input logic [7:0] ahi, input logic [7:0] alo, input logic [15:0] d);
      apb(1'b1, ahi, d[15:8]);
      apb(1'b1, alo, d[7:0]);
   endtask
   task r16(input logic [7:0] alo, input logic [7:0] ahi);
      apb(1'b0, alo, 8'h00);
      v[7:0] = rd[7:0];
      apb(1'b0, ahi, 8'h00);
      v[15:8] = rd[7:0];
   endtask
   task pulse_ack;
      @(posedge pclk);
      cap_irq_ack <= 1'b1;
      @(posedge pclk);
      cap_irq_ack <= 1'b0;
   endtask
   initial begin
      {psel, penable, pwrite, ovf_irq_ack, cap_irq_ack} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      pins = 3'h0;
      err_total = 0;
      checks = 0;
      presetn = 1'b0;
      tick(8);
      presetn <= 1'b1;
      apb(1'b0, `TCC_OFF_CTRL_B, 8'h00);
      `CHK("ctrl_b rst", 8'h00, rd[7:0])
      r16(`TCC_OFF_CMPA_LO, `TCC_OFF_CMPA_HI);
      `CHK("cmpa rst", `TCC_RST_CMPA, v)
      apb(1'b0, 8'h2c, 8'h00);
      `CHK("unmapped err", 1'b1, serr)
      `CHK("unmapped data", 32'h00000000, rd)
      $display("test reset done");
      w16(`TCC_OFF_CNT_HI, `TCC_OFF_CNT_LO, 16'h1234);
      tick(20);
      r16(`TCC_OFF_CNT_LO, `TCC_OFF_CNT_HI);
      `CHK("count stopped", 16'h1234, v)
      apb(1'b1, `TCC_OFF_CNT_HI, 8'hab);
      apb(1'b1, `TCC_OFF_CNT_LO, 8'h01);
      // shared holding byte reused for a second register
      apb(1'b1, `TCC_OFF_CMPA_LO, 8'h02);
      r16(`TCC_OFF_CMPA_LO, `TCC_OFF_CMPA_HI);
      `CHK("cmpa shared hi", 16'hab02, v)
      $display("test holding done");
      // count crosses ff during the read, so a late holding copy shows 01ff
      w16(`TCC_OFF_CNT_HI, `TCC_OFF_CNT_LO, 16'h00fd);
      apb(1'b1, `TCC_OFF_CTRL_B, 8'h01);
      r16(`TCC_OFF_CNT_LO, `TCC_OFF_CNT_HI);
      `CHK("coherent hi", {7'h00, v[7:0] < 8'h80}, v[15:8])
      w16(`TCC_OFF_CNT_HI, `TCC_OFF_CNT_LO, 16'hfff0);
      r16(`TCC_OFF_CNT_LO, `TCC_OFF_CNT_HI);
      `CHK("write wins", 1'b1, v >= 16'hfff0 && v < 16'hfff8)
      apb(1'b1, `TCC_OFF_IRQ_EN, 8'h01);
      tick(30);
      apb(1'b0, `TCC_OFF_FLAGS, 8'h00);
      `CHK("ovf flag", 1'b1, rd[`TCC_F_OVF])
      `CHK("ovf irq", 1'b1, ovf_irq_q)
      @(posedge pclk);
      ovf_irq_ack <= 1'b1;
      @(posedge pclk);
      ovf_irq_ack <= 1'b0;
      tick(2);
      `CHK("ovf irq ack", 1'b0, ovf_irq_q)
      r16(`TCC_OFF_CNT_LO, `TCC_OFF_CNT_HI);
      `CHK("wrapped count", 1'b1, v < 16'h0100)
      // stop first so no pclk-rate ticks leak into the first rate window
      apb(1'b1, `TCC_OFF_CTRL_B, 8'h00);
      // every tick source at its model rate
      for (int k = 2; k < 8; k++) begin
         w16(`TCC_OFF_CNT_HI, `TCC_OFF_CNT_LO, 16'h0000);
         apb(1'b1, `TCC_OFF_CTRL_B, k[7:0]);
         tick(64);
         apb(1'b1, `TCC_OFF_CTRL_B, 8'h00);
         r16(`TCC_OFF_CNT_LO, `TCC_OFF_CNT_HI);
         `CHK("tick rate", 1'b1, v + 1 >= 64 >> (k < 6 ? k - 1 : 4) && v <= 1 + (72 >> (k < 6 ? k - 1 : 4)))
      end
      $display("test counting done");
      apb(1'b1, `TCC_OFF_CTRL_B, 8'h40);
      apb(1'b1, `TCC_OFF_IRQ_EN, 8'h20);
      for (int s = 0; s < 3; s++) begin
         apb(1'b1, `TCC_OFF_CTRL_C, s[7:0]);
         w16(`TCC_OFF_CNT_HI, `TCC_OFF_CNT_LO, {8'h40 + s[7:0], 8'h21});
         // a source switch may capture, so the flag is cleared after it
         apb(1'b1, `TCC_OFF_FLAGS, 8'h21);
         pins[s] <= 1'b1;
         tick(6);
         `CHK("cap irq", 1'b1, cap_irq_q)
         r16(`TCC_OFF_CAP_LO, `TCC_OFF_CAP_HI);
         `CHK("cap value", {8'h40 + s[7:0], 8'h21}, v)
         if (s == 2) pulse_ack();
         else apb(1'b1, `TCC_OFF_FLAGS, 8'h20);
         apb(1'b0, `TCC_OFF_FLAGS, 8'h00);
         `CHK("cap flag clear", 1'b0, rd[`TCC_F_CAP])
         pins[s] <= 1'b0;
      end
      $display("test capture done");
      apb(1'b1, `TCC_OFF_CTRL_C, 8'h00);
      apb(1'b1, `TCC_OFF_CTRL_B, 8'hc0);
      apb(1'b1, `TCC_OFF_FLAGS, 8'h20);
      pins[0] <= 1'b1;
      tick(3);
      pins[0] <= 1'b0;
      tick(10);
      `CHK("short pulse", 1'b0, cap_irq_q)
      // unfiltered irq shows 4 edges after the pin, filtered exactly 4 later
      pins[0] <= 1'b1;
      tick(7);
      `CHK("filter delay", 1'b0, cap_irq_q)
      tick(1);
      `CHK("filter capture", 1'b1, cap_irq_q)
      pins[0] <= 1'b0;
      tick(10);
      apb(1'b1, `TCC_OFF_CTRL_B, 8'h58);
      w16(`TCC_OFF_CAP_HI, `TCC_OFF_CAP_LO, 16'h0506);
      apb(1'b1, `TCC_OFF_FLAGS, 8'h20);
      pins[0] <= 1'b1;
      tick(8);
      `CHK("input off", 1'b0, cap_irq_q)
      pins[0] <= 1'b1;
      apb(1'b1, `TCC_OFF_CTRL_B, 8'h00);
      w16(`TCC_OFF_CAP_HI, `TCC_OFF_CAP_LO, 16'h0708);
      r16(`TCC_OFF_CAP_LO, `TCC_OFF_CAP_HI);
      `CHK("cap write", 16'h0506, v)
      $display("test filter and mode done");
      // mode 5 needs the low mode bits of control a: top 00ff, single slope
      pins[0] <= 1'b0;
      apb(1'b1, `TCC_OFF_CTRL_A, 8'h01);
      w16(`TCC_OFF_CNT_HI, `TCC_OFF_CNT_LO, 16'h00f0);
      apb(1'b1, `TCC_OFF_FLAGS, 8'h21);
      apb(1'b1, `TCC_OFF_CTRL_B, 8'h09);
      tick(40);
      r16(`TCC_OFF_CNT_LO, `TCC_OFF_CNT_HI);
      `CHK("single top", 1'b1, v < 16'h0100)
      apb(1'b0, `TCC_OFF_FLAGS, 8'h00);
      `CHK("top ovf", 1'b1, rd[`TCC_F_OVF])
      // mode 1: dual slope to 00ff, turns down after the top
      apb(1'b1, `TCC_OFF_CTRL_B, 8'h00);
      w16(`TCC_OFF_CNT_HI, `TCC_OFF_CNT_LO, 16'h00f8);
      apb(1'b1, `TCC_OFF_CTRL_B, 8'h01);
      tick(20);
      r16(`TCC_OFF_CNT_LO, `TCC_OFF_CNT_HI);
      `CHK("dual slope", 1'b1, v >= 16'h00e0 && v <= 16'h00ff)
      // retrigger: a capture on pin a acts as top in normal mode
      apb(1'b1, `TCC_OFF_CTRL_A, 8'h00);
      apb(1'b1, `TCC_OFF_CTRL_B, 8'h40);
      apb(1'b1, `TCC_OFF_CTRL_C, 8'h04);
      w16(`TCC_OFF_CNT_HI, `TCC_OFF_CNT_LO, 16'h1000);
      apb(1'b1, `TCC_OFF_FLAGS, 8'h21);
      apb(1'b1, `TCC_OFF_CTRL_B, 8'h41);
      tick(4);
      pins[0] <= 1'b1;
      tick(6);
      r16(`TCC_OFF_CNT_LO, `TCC_OFF_CNT_HI);
      `CHK("retrig count", 1'b1, v < 16'h0010)
      apb(1'b0, `TCC_OFF_FLAGS, 8'h00);
      `CHK("retrig top", 1'b1, rd[`TCC_F_OVF])
      r16(`TCC_OFF_CAP_LO, `TCC_OFF_CAP_HI);
      `CHK("retrig cap", 1'b1, v >= 16'h1000 && v < 16'h1010)
      $display("test top and retrigger done");
      wrap_up();
   end
endmodule
